// ==== inc/gpab_defs.svh ====
// Register offsets, widths and reset values for the two-port GPIO block
`ifndef GPAB_DEFS_SVH
`define GPAB_DEFS_SVH

`define GPAB_PORT_W       8
`define GPAB_CHSEL_W      5
`define GPAB_BUS_DW       32
`define GPAB_BUS_AW       8

// Byte offsets on the bus; each register is one aligned word
`define GPAB_OFF_A_DATA   8'h00
`define GPAB_OFF_A_DIR    8'h04
`define GPAB_OFF_A_PUE    8'h08
`define GPAB_OFF_B_DATA   8'h0c
`define GPAB_OFF_B_DIR    8'h10

`define GPAB_DIR_RST      8'h00
`define GPAB_PUE_RST      8'h00
`define GPAB_RD_UNMAPPED  32'h0000_0000

`endif

// ==== inc/gpab_pkg.sv ====
// Types shared by the two-port GPIO block
package gpab_pkg;
  // Drive side of one 8-bit port: level and output enable per pin
  typedef struct packed {
    logic [7:0] level;
    logic [7:0] oe;
  } gpab_drive_s;
endpackage

// ==== core/gpab_sync.sv ====
// Two-flop synchroniser for pin levels entering the core clock domain
module gpab_sync #(
  parameter int WIDTH = 16
) (
  input  wire logic             core_clk_in,
  input  wire logic             rst_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;
endmodule

// ==== core/gpab_port.sv ====
// Two 8-bit GPIO ports, pull-ups on port A only, keypad sharing and converter override, Wishbone slave
//
// Our own choice: the Wishbone slave port.
`include "gpab_defs.svh"

// Contract
// - Port A data latches survive reset
// - Port A direction 1 enables driver
// - Reset clears port A direction bits
// - Port A read returns latch for outputs
// - Port A read returns pin for inputs
// - Latch always writable, pin read unaffected
// - Pull-up only when enabled and input
// - Pull-up enable bits individually writable
// - Port A pins feed keypad interrupt enables
// - Port B data latches survive reset
// - Converter-selected port B pin forced analog
// - Unselected port B pins stay digital
// - Port B direction 1 enables driver
// - Port B read: latch outputs, pin inputs
// - Reset clears port B direction bits
module gpab_port (
  input  wire logic                    core_clk_in,
  input  wire logic                    rst_in,
  input  wire logic                    wb_cyc_in,
  input  wire logic                    wb_stb_in,
  input  wire logic                    wb_we_in,
  input  wire logic [7:0]              wb_adr_in,
  input  wire logic [3:0]              wb_sel_in,
  input  wire logic [31:0]             wb_dat_in,
  output logic      [31:0]             wb_dat_out,
  output logic                         wb_ack_out,
  input  wire logic [7:0]              first_port_pin_in,
  output gpab_pkg::gpab_drive_s        first_port_drive_out,
  output logic      [7:0]              first_port_pullup_out,
  input  wire logic [7:0]              second_port_pin_in,
  output gpab_pkg::gpab_drive_s        second_port_drive_out,
  output logic      [7:0]              analog_inputs_out,
  input  wire logic [7:0]              keypad_irq_pin_enables_in,
  output logic      [7:0]              keypad_inputs_out,
  input  wire logic [4:0]              converter_channel_select_in
);
  import gpab_pkg::*;

  logic [7:0]  pa_sync;
  logic [7:0]  pb_sync;

  // Data latches: no reset, reset leaves them as they were
  logic [7:0]  pa_lat_q;
  logic [7:0]  pa_lat_d;
  logic [7:0]  pb_lat_q;
  logic [7:0]  pb_lat_d;

  // Control registers
  logic [7:0]  pa_dir_q;
  logic [7:0]  pa_dir_d;
  logic [7:0]  pa_pue_q;
  logic [7:0]  pa_pue_d;
  logic [7:0]  pb_dir_q;
  logic [7:0]  pb_dir_d;

  // Bus slave state
  logic        ack_q;
  logic        ack_d;
  logic [31:0] dat_q;
  logic [31:0] dat_d;

  // Registered outputs
  gpab_drive_s pa_drv_q;
  gpab_drive_s pa_drv_d;
  gpab_drive_s pb_drv_q;
  gpab_drive_s pb_drv_d;
  logic [7:0]  pa_pull_q;
  logic [7:0]  pa_pull_d;
  logic [7:0]  an_q;
  logic [7:0]  an_d;
  logic [7:0]  kbd_q;
  logic [7:0]  kbd_d;

  logic        req;
  logic        wr_commit;
  logic [5:0]  widx;

  // Per bit: latch where the pin is driven, pin level where it is not
  function automatic logic [7:0] read_mix(input logic [7:0] drv, input logic [7:0] lat,
                                          input logic [7:0] pin);
    read_mix = (drv & lat) | (~drv & pin);
  endfunction

  // Channel codes past the last port pin select no pin of this port
  function automatic logic [7:0] chan_onehot(input logic [4:0] sel);
    logic [7:0] oh;
    oh = 8'h00;
    if (sel < 5'h08) begin
      oh[sel[2:0]] = 1'b1;
    end
    chan_onehot = oh;
  endfunction

  gpab_sync #(
    .WIDTH(16)
  ) u_sync (
    .core_clk_in(core_clk_in),
    .rst_in     (rst_in),
    .async_in   ({second_port_pin_in, first_port_pin_in}),
    .sync_out   ({pb_sync, pa_sync})
  );

  assign req       = wb_cyc_in & wb_stb_in;
  assign widx      = wb_adr_in[7:2];
  // A write lands only on the edge where the master sees ack
  assign wr_commit = req & wb_we_in & ack_q & wb_sel_in[0];

  always_comb begin
    pa_lat_d = pa_lat_q;
    pb_lat_d = pb_lat_q;
    pa_dir_d = pa_dir_q;
    pa_pue_d = pa_pue_q;
    pb_dir_d = pb_dir_q;
    if (wr_commit) begin
      case (widx)
        `GPAB_OFF_A_DATA >> 2: pa_lat_d = wb_dat_in[7:0];
        `GPAB_OFF_A_DIR >> 2:  pa_dir_d = wb_dat_in[7:0];
        `GPAB_OFF_A_PUE >> 2:  pa_pue_d = wb_dat_in[7:0];
        `GPAB_OFF_B_DATA >> 2: pb_lat_d = wb_dat_in[7:0];
        `GPAB_OFF_B_DIR >> 2:  pb_dir_d = wb_dat_in[7:0];
        default: begin
        end
      endcase
    end
  end

  // Single wait state: ack one cycle after the request, dropped the cycle after
  always_comb begin
    ack_d = req & ~ack_q;
    dat_d = `GPAB_RD_UNMAPPED;
    if (req & ~ack_q & ~wb_we_in) begin
      case (widx)
        `GPAB_OFF_A_DATA >> 2: dat_d = {24'h000000, read_mix(pa_dir_q, pa_lat_q, pa_sync)};
        `GPAB_OFF_A_DIR >> 2:  dat_d = {24'h000000, pa_dir_q};
        `GPAB_OFF_A_PUE >> 2:  dat_d = {24'h000000, pa_pue_q};
        // An analog pin has no digital driver, so it reads as the pin
        `GPAB_OFF_B_DATA >> 2: dat_d = {24'h000000, read_mix(pb_dir_q & ~an_q, pb_lat_q, pb_sync)};
        `GPAB_OFF_B_DIR >> 2:  dat_d = {24'h000000, pb_dir_q};
        default:               dat_d = `GPAB_RD_UNMAPPED;
      endcase
    end
  end

  // Outputs follow the next register values so a write shows at the ack edge
  always_comb begin
    pa_drv_d.oe    = pa_dir_d;
    pa_drv_d.level = pa_lat_d & pa_dir_d;
    // Pull-up drops out as soon as the pin turns output
    pa_pull_d      = pa_pue_d & ~pa_dir_d;
    an_d           = chan_onehot(converter_channel_select_in);
    pb_drv_d.oe    = pb_dir_d & ~an_d;
    pb_drv_d.level = pb_lat_d & pb_dir_d & ~an_d;
    kbd_d          = pa_sync & keypad_irq_pin_enables_in;
  end

  // Latches deliberately carry no reset
  always_ff @(posedge core_clk_in) begin
    pa_lat_q <= pa_lat_d;
    pb_lat_q <= pb_lat_d;
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pa_dir_q  <= `GPAB_DIR_RST;
      pa_pue_q  <= `GPAB_PUE_RST;
      pb_dir_q  <= `GPAB_DIR_RST;
      ack_q     <= 1'b0;
      dat_q     <= `GPAB_RD_UNMAPPED;
      pa_drv_q  <= '0;
      pb_drv_q  <= '0;
      pa_pull_q <= 8'h00;
      an_q      <= 8'h00;
      kbd_q     <= 8'h00;
    end else begin
      pa_dir_q  <= pa_dir_d;
      pa_pue_q  <= pa_pue_d;
      pb_dir_q  <= pb_dir_d;
      ack_q     <= ack_d;
      dat_q     <= dat_d;
      pa_drv_q  <= pa_drv_d;
      pb_drv_q  <= pb_drv_d;
      pa_pull_q <= pa_pull_d;
      an_q      <= an_d;
      kbd_q     <= kbd_d;
    end
  end

  assign wb_ack_out            = ack_q;
  assign wb_dat_out            = dat_q;
  assign first_port_drive_out  = pa_drv_q;
  assign second_port_drive_out = pb_drv_q;
  assign first_port_pullup_out = pa_pull_q;
  assign analog_inputs_out     = an_q;
  assign keypad_inputs_out     = kbd_q;

  sequence s_rd_req(logic [7:0] off);
    req && !wb_we_in && !ack_q && wb_adr_in[7:2] == off[7:2];
  endsequence

  sequence s_wr_done(logic [7:0] off);
    wr_commit && wb_adr_in[7:2] == off[7:2];
  endsequence

  a_lat_a_hold: assert property (@(posedge core_clk_in)
    rst_in |=> pa_lat_q === $past(pa_lat_q))
    else $error("Port A latch changed during reset");

  a_lat_b_hold: assert property (@(posedge core_clk_in)
    rst_in |=> pb_lat_q === $past(pb_lat_q))
    else $error("Port B latch changed during reset");

  a_dir_reset_clear: assert property (@(posedge core_clk_in)
    $fell(rst_in) |-> pa_dir_q == 8'h00 && pb_dir_q == 8'h00 && pa_drv_q.oe == 8'h00)
    else $error("Direction not cleared by reset");

  a_dir_a_drive: assert property (@(posedge core_clk_in) disable iff (rst_in)
    s_wr_done(`GPAB_OFF_A_DIR) |=> first_port_drive_out.oe == $past(wb_dat_in[7:0]))
    else $error("Port A driver enable does not follow direction");

  a_read_a_mix: assert property (@(posedge core_clk_in) disable iff (rst_in)
    s_rd_req(`GPAB_OFF_A_DATA) |=> wb_ack_out &&
      wb_dat_out[7:0] == (($past(pa_dir_q) & $past(pa_lat_q)) | (~$past(pa_dir_q) & $past(pa_sync))))
    else $error("Port A read mixes latch and pin wrongly");

  a_write_input_bit: assert property (@(posedge core_clk_in) disable iff (rst_in)
    s_wr_done(`GPAB_OFF_A_DATA) |=> pa_lat_q == $past(wb_dat_in[7:0]))
    else $error("Port A latch write lost");

  a_pullup_gating: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (first_port_pullup_out & first_port_drive_out.oe) == 8'h00)
    else $error("Pull-up on while pin drives");

  a_pue_write: assert property (@(posedge core_clk_in) disable iff (rst_in)
    s_wr_done(`GPAB_OFF_A_PUE) |=> pa_pue_q == $past(wb_dat_in[7:0]) &&
      first_port_pullup_out == ($past(wb_dat_in[7:0]) & ~pa_dir_q))
    else $error("Pull-up enable write not applied");

  a_keypad_feed: assert property (@(posedge core_clk_in) disable iff (rst_in)
    ##1 keypad_inputs_out == ($past(pa_sync) & $past(keypad_irq_pin_enables_in)))
    else $error("Keypad input not gated by enables");

  a_analog_force: assert property (@(posedge core_clk_in) disable iff (rst_in)
    converter_channel_select_in < 5'h08 |=>
      !second_port_drive_out.oe[$past(converter_channel_select_in[2:0])] &&
      analog_inputs_out[$past(converter_channel_select_in[2:0])])
    else $error("Selected analog pin still driven");

  a_digital_b: assert property (@(posedge core_clk_in) disable iff (rst_in)
    second_port_drive_out.oe == (pb_dir_q & ~analog_inputs_out))
    else $error("Port B driver enable wrong");

  a_read_b_mix: assert property (@(posedge core_clk_in) disable iff (rst_in)
    s_rd_req(`GPAB_OFF_B_DATA) ##1 wb_ack_out |->
      wb_dat_out[7:0] == $past(read_mix(pb_dir_q & ~an_q, pb_lat_q, pb_sync)))
    else $error("Port B read mixes latch and pin wrongly");

  a_write_to_pins: assert property (@(posedge core_clk_in) disable iff (rst_in)
    s_wr_done(`GPAB_OFF_B_DIR) |=> pb_dir_q == $past(wb_dat_in[7:0]) &&
      second_port_drive_out.oe == ($past(wb_dat_in[7:0]) & ~analog_inputs_out))
    else $error("Port B direction write late at pins");

  a_pb_float: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (~second_port_drive_out.oe & second_port_drive_out.level) == 8'h00)
    else $error("Port B level driven with driver off");

  a_ack_one_cycle: assert property (@(posedge core_clk_in) disable iff (rst_in)
    wb_ack_out |=> !wb_ack_out)
    else $error("Ack held longer than one cycle");
endmodule

// ==== verif/gpab_pins.sv ====
// Pin-side model: resolves both ports' wires from core drive, pull-ups and outside sources
module gpab_pins (
  input  wire gpab_pkg::gpab_drive_s a_drv_in,
  input  wire logic [7:0]            a_pu_in,
  input  wire logic [7:0]            a_ext_in,
  input  wire logic [7:0]            a_ext_en_in,
  input  wire gpab_pkg::gpab_drive_s b_drv_in,
  input  wire logic [7:0]            b_ext_in,
  output logic      [7:0]            a_pin_out,
  output logic      [7:0]            b_pin_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // A floating pin without pull-up shows the inverse of the level input, which the core holds at 0 with the driver off, so it reads high, never a kind value
  assign a_pin_out = (a_drv_in.oe & a_drv_in.level) | (~a_drv_in.oe & ((a_ext_en_in & a_ext_in) |
                     (~a_ext_en_in & (a_pu_in | ~a_drv_in.level))));
  // Port B has no pull-ups; the outside source always drives it when the core does not
  assign b_pin_out = (b_drv_in.oe & b_drv_in.level) | (~b_drv_in.oe & b_ext_in);
endmodule

// ==== verif/test_gpab_port.sv ====
// Self-checking bench for the two-port GPIO block against an integer register model
`include "gpab_defs.svh"
module test_gpab_port;
  timeunit 1ns;
  timeprecision 1ns;
  import gpab_pkg::*;
  logic        core_clk_in, rst_in, cyc, stb, we, ack;
  logic [7:0]  adr, pa, pb, xa, xb, xa_en, kbe, pu, an, kbo;
  logic [3:0]  sel;
  logic [4:0]  chs;
  logic [31:0] wdat, rdat, rd;
  gpab_drive_s da, db;
  int          miscompares = 0;
  int          samples_checked = 0;
  int          la = 0, lb = 0, ra = 0, rb = 0, pe = 0;
  gpab_port DUT (.core_clk_in(core_clk_in), .rst_in(rst_in), .wb_cyc_in(cyc), .wb_stb_in(stb),
    .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(rdat),
    .wb_ack_out(ack), .first_port_pin_in(pa), .first_port_drive_out(da), .first_port_pullup_out(pu),
    .second_port_pin_in(pb), .second_port_drive_out(db), .analog_inputs_out(an),
    .keypad_irq_pin_enables_in(kbe), .keypad_inputs_out(kbo), .converter_channel_select_in(chs));
  gpab_pins PINS (.a_drv_in(da), .a_pu_in(pu), .a_ext_in(xa), .a_ext_en_in(xa_en), .b_drv_in(db),
    .b_ext_in(xb), .a_pin_out(pa), .b_pin_out(pb));
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // One classic cycle; held until ack is sampled high, only the watchdog ends a hung wait
  task automatic bus(input logic w, input logic [7:0] a, input int d, input logic [3:0] s);
    @(posedge core_clk_in);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= 32'(d & 8'hff);
    @(posedge core_clk_in);
    while (ack !== 1'b1) begin
      @(posedge core_clk_in);
    end
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic check_all();
    int pina, ob, anx;
    anx = (chs < 8) ? (1 << chs) : 0;
    ob = rb & ~anx & 8'hff;
    pina = ((ra & la) | (~ra & ((xa_en & xa) | ~xa_en))) & 8'hff;
    check("a drive", 32'(da), ((la & ra) << 8) | ra);
    check("a pullup", 32'(pu), pe & ~ra & 8'hff);
    check("b drive", 32'(db), ((lb & ob) << 8) | ob);
    check("analog", 32'(an), anx);
    check("keypad", 32'(kbo), pina & kbe);
    bus(1'b0, `GPAB_OFF_A_DATA, 0, 4'hf);
    check("a read", rd, pina);
    bus(1'b0, `GPAB_OFF_A_DIR, 0, 4'hf);
    check("a dir", rd, ra);
    bus(1'b0, `GPAB_OFF_A_PUE, 0, 4'hf);
    check("a pue", rd, pe);
    bus(1'b0, `GPAB_OFF_B_DATA, 0, 4'hf);
    check("b read", rd, (ob & lb) | (~ob & xb & 8'hff));
    bus(1'b0, `GPAB_OFF_B_DIR, 0, 4'hf);
    check("b dir", rd, rb);
  endtask
  initial begin
    core_clk_in = 1'b0;
    forever #20 core_clk_in = ~core_clk_in;
  end
  initial begin
    repeat (20000) @(posedge core_clk_in);
    miscompares++;
    give_verdict();
  end
  initial begin
    {rst_in, cyc, stb, we, adr, sel, wdat} = {1'b1, 47'h0};
    {xa, xb, xa_en, kbe, chs} = {16'h0, 8'hff, 8'h0, 5'h1f};
    void'($urandom(32'hf36f1964));
    repeat (16) @(posedge core_clk_in);
    check("reset outputs", 32'({da.oe, db.oe, pu, an}), 0);
    rst_in <= 1'b0;
    repeat (4) @(posedge core_clk_in);
    check_all();
    $display("test reset done");
    for (int i = 0; i < 40; i++) begin
      la = $urandom & 8'hff;
      lb = $urandom & 8'hff;
      pe = $urandom & 8'hff;
      // Latches loaded before any direction change so pins switch cleanly
      bus(1'b1, `GPAB_OFF_A_DATA, la, 4'hf);
      bus(1'b1, `GPAB_OFF_B_DATA, lb, 4'hf);
      bus(1'b1, `GPAB_OFF_A_PUE, pe, 4'hf);
      xa <= 8'($urandom);
      xa_en <= 8'($urandom) | ~8'(pe);
      xb <= 8'($urandom);
      kbe <= 8'($urandom);
      chs <= 5'($urandom);
      ra = $urandom & 8'hff;
      rb = $urandom & 8'hff;
      bus(1'b1, `GPAB_OFF_A_DIR, ra, 4'hf);
      @(negedge core_clk_in);
      check("a oe edge", 32'(da.oe), ra);
      bus(1'b1, `GPAB_OFF_B_DIR, rb, 4'hf);
      repeat (4) @(posedge core_clk_in);
      check_all();
    end
    $display("test random traffic done");
    rst_in <= 1'b1;
    chs <= 5'h1f;
    @(negedge core_clk_in);
    check("reset again", 32'({da.oe, db.oe, pu, an}), 0);
    @(posedge core_clk_in);
    rst_in <= 1'b0;
    ra = 0;
    rb = 0;
    pe = 0;
    repeat (4) @(posedge core_clk_in);
    check_all();
    ra = 8'hff;
    rb = 8'hff;
    bus(1'b1, `GPAB_OFF_A_DIR, ra, 4'hf);
    bus(1'b1, `GPAB_OFF_B_DIR, rb, 4'hf);
    bus(1'b0, `GPAB_OFF_A_DATA, 0, 4'hf);
    check("a latch kept", rd, la);
    bus(1'b0, `GPAB_OFF_B_DATA, 0, 4'hf);
    check("b latch kept", rd, lb);
    bus(1'b1, `GPAB_OFF_A_DATA, ~la, 4'he);
    bus(1'b0, `GPAB_OFF_A_DATA, 0, 4'hf);
    check("low byte unselected", rd, la);
    bus(1'b1, 8'h20, 8'h5a, 4'hf);
    bus(1'b0, 8'h20, 0, 4'hf);
    check("unmapped", rd, `GPAB_RD_UNMAPPED);
    check_all();
    $display("test reset keeps latches done");
    give_verdict();
  end
endmodule
